// file: shared/isfc_regs.vh
// Register map and constants for the ident, scratch and flash tally bank
`ifndef ISFC_REGS_VH
`define ISFC_REGS_VH

// ----------------------------------------------------------------
// Word addresses (even byte address of each pair)
// ----------------------------------------------------------------
`define ISFC_ADDR_W 7
`define ISFC_A_CMD 7'h68
`define ISFC_A_MDAY 7'h6e
`define ISFC_A_YEAR 7'h70
`define ISFC_A_PROD 7'h72
`define ISFC_A_LOT 7'h74
`define ISFC_A_NOTE_A 7'h76
`define ISFC_A_NOTE_B 7'h78
`define ISFC_A_NOTE_C 7'h7a
`define ISFC_A_TALLY_LO 7'h7c
`define ISFC_A_TALLY_HI 7'h7e

// ----------------------------------------------------------------
// Command byte field, reset values, note count and indices
// ----------------------------------------------------------------
`define ISFC_CMD_BACKUP_BIT 3
`define ISFC_NOTE_RST 16'h0000
`define ISFC_TALLY_RST 32'h0000_0000
`define ISFC_TALLY_ONE 32'h0000_0001
`define ISFC_NOTES 3
`define ISFC_NOTE_IDX_W 2
`define ISFC_IDX_A 2'h0
`define ISFC_IDX_B 2'h1
`define ISFC_IDX_C 2'h2
`define ISFC_ZERO16 16'h0000

`endif

// file: hdl/isfc_nvm_store.v
// Nonvolatile image of the scratch words, written only on backup
`include "isfc_regs.vh"

module isfc_nvm_store #(
	parameter DW = 16,
	parameter AW = 2,
	parameter DEPTH = 3
) (
	// Clock
	input wire i_core_clk,
	// Write port
	input wire i_wr_en,
	input wire [AW-1:0] i_wr_idx,
	input wire [DW-1:0] i_wr_data,
	// Read port
	input wire [AW-1:0] i_rd_idx,
	output reg [DW-1:0] o_rd_data
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// No reset: contents model retention across device reset
	reg [DW-1:0] mem_r [0:DEPTH-1];

	always @(posedge i_core_clk) begin
		if (i_wr_en) begin
			mem_r[i_wr_idx] <= i_wr_data;
		end
		o_rd_data <= mem_r[i_rd_idx];
	end

endmodule // isfc_nvm_store

// file: hdl/isfc_bank.v
// Identification, scratch and flash write tally register bank
`include "isfc_regs.vh"

module isfc_bank #(
	parameter [15:0] MONTH_DAY = 16'h0101,
	parameter [15:0] YEAR = 16'h2000,
	// Arbitrary neutral product code
	parameter [15:0] PRODUCT_CODE = 16'h1234,
	parameter [15:0] LOT_CODE = 16'h0001
) (
	// Clock and reset
	input wire i_core_clk,
	input wire i_sys_rst,
	// Register write
	input wire i_wr_en,
	input wire [6:0] i_wr_addr,
	input wire [7:0] i_wr_data,
	// Register read
	input wire i_rd_en,
	input wire [6:0] i_rd_addr,
	output reg [15:0] o_rd_data,
	// Flash backup activity
	output wire o_backup_busy,
	output reg o_backup_done
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Byte address to word address, dropping the odd-byte bit
	function [6:0] word_of;
		input [6:0] a;
		begin
			word_of = {a[6:1], 1'b0};
		end
	endfunction

	localparam ST_IDLE = 2'h0;
	localparam ST_COPY = 2'h1;
	localparam ST_DONE = 2'h2;

	reg [15:0] note_a_r;
	reg [15:0] note_b_r;
	reg [15:0] note_c_r;
	reg [31:0] tally_r;
	reg [1:0] st_r;
	reg [1:0] idx_r;
	reg [15:0] copy_data;
	wire [6:0] wa;
	wire [6:0] ra;
	wire hi_byte;

	assign wa = word_of(i_wr_addr);
	assign ra = word_of(i_rd_addr);
	assign hi_byte = i_wr_addr[0];
	assign o_backup_busy = (st_r != ST_IDLE);

	// ----------------------------------------------------------------
	// Scratch words, byte writes
	// ----------------------------------------------------------------
	// Serial frames carry one byte; odd address hits the upper byte
	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			note_a_r <= `ISFC_NOTE_RST;
			note_b_r <= `ISFC_NOTE_RST;
			note_c_r <= `ISFC_NOTE_RST;
		end else if (i_wr_en && !o_backup_busy) begin
			case (wa)
			`ISFC_A_NOTE_A: begin
				if (hi_byte) note_a_r[15:8] <= i_wr_data;
				else note_a_r[7:0] <= i_wr_data;
			end
			`ISFC_A_NOTE_B: begin
				if (hi_byte) note_b_r[15:8] <= i_wr_data;
				else note_b_r[7:0] <= i_wr_data;
			end
			`ISFC_A_NOTE_C: begin
				if (hi_byte) note_c_r[15:8] <= i_wr_data;
				else note_c_r[7:0] <= i_wr_data;
			end
			default: begin
				// Read-only and unmapped words drop the write
				note_a_r <= note_a_r;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Backup sequencer
	// ----------------------------------------------------------------
	// Backup starts on low command byte with bit 3; terminating word
	// to the upper byte carries no command and is ignored
	wire backup_req = i_wr_en && !hi_byte && (wa == `ISFC_A_CMD) &&
		i_wr_data[`ISFC_CMD_BACKUP_BIT];

	always @* begin
		case (idx_r)
		`ISFC_IDX_A: copy_data = note_a_r;
		`ISFC_IDX_B: copy_data = note_b_r;
		default: copy_data = note_c_r;
		endcase
	end

	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			st_r <= ST_IDLE;
			idx_r <= `ISFC_IDX_A;
			tally_r <= `ISFC_TALLY_RST;
			o_backup_done <= 1'b0;
		end else begin
			o_backup_done <= 1'b0;
			case (st_r)
			ST_IDLE: begin
				if (backup_req) begin
					st_r <= ST_COPY;
					idx_r <= `ISFC_IDX_A;
				end
			end
			ST_COPY: begin
				if (idx_r == `ISFC_IDX_C) st_r <= ST_DONE;
				else idx_r <= idx_r + 2'h1;
			end
			ST_DONE: begin
				tally_r <= tally_r + `ISFC_TALLY_ONE;
				o_backup_done <= 1'b1;
				st_r <= ST_IDLE;
			end
			default: st_r <= ST_IDLE;
			endcase
		end
	end

	isfc_nvm_store #(
		.DW(16),
		.AW(`ISFC_NOTE_IDX_W),
		.DEPTH(`ISFC_NOTES)
	) u_store (
		.i_core_clk(i_core_clk),
		.i_wr_en(st_r == ST_COPY),
		.i_wr_idx(idx_r),
		.i_wr_data(copy_data),
		.i_rd_idx(idx_r),
		.o_rd_data()
	);

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_rd_data <= `ISFC_ZERO16;
		end else if (i_rd_en) begin
			case (ra)
			`ISFC_A_MDAY: o_rd_data <= MONTH_DAY;
			`ISFC_A_YEAR: o_rd_data <= YEAR;
			`ISFC_A_PROD: o_rd_data <= PRODUCT_CODE;
			`ISFC_A_LOT: o_rd_data <= LOT_CODE;
			`ISFC_A_NOTE_A: o_rd_data <= note_a_r;
			`ISFC_A_NOTE_B: o_rd_data <= note_b_r;
			`ISFC_A_NOTE_C: o_rd_data <= note_c_r;
			`ISFC_A_TALLY_LO: o_rd_data <= tally_r[15:0];
			`ISFC_A_TALLY_HI: o_rd_data <= tally_r[31:16];
			default: o_rd_data <= `ISFC_ZERO16;
			endcase
		end
	end

endmodule // isfc_bank

// file: test/isfc_bank_asserts.sv
// Checker for the ident, scratch and tally bank
module isfc_bank_asserts (
	input wire i_core_clk,
	input wire i_sys_rst,
	input wire i_wr_en,
	input wire [6:0] i_wr_addr,
	input wire [7:0] i_wr_data,
	input wire i_rd_en,
	input wire [6:0] i_rd_addr,
	input wire [15:0] o_rd_data,
	input wire o_backup_busy,
	input wire o_backup_done
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	wire go = i_wr_en && i_wr_addr == 7'h68 && i_wr_data[3] && !o_backup_busy;
	wire [5:0] ra = i_rd_addr[6:1];
	a_backup_done: assert property (go |-> ##5 o_backup_done)
		else $error("backup done not on time");
	a_busy_four: assert property ($rose(o_backup_busy) |->
		o_backup_busy[*4] ##1 !o_backup_busy)
		else $error("busy length wrong");
	a_done_tail: assert property (o_backup_done |->
		$past(o_backup_busy) && !o_backup_busy)
		else $error("done outside backup");
	a_read_mday: assert property (i_rd_en && ra == 6'h37 |=>
		o_rd_data == 16'h0101)
		else $error("month day word wrong");
	a_read_year: assert property (i_rd_en && ra == 6'h38 |=>
		o_rd_data == 16'h2000)
		else $error("year word wrong");
	a_read_prod: assert property (i_rd_en && ra == 6'h39 |=>
		o_rd_data == 16'h1234)
		else $error("product word wrong");
	a_read_lot: assert property (i_rd_en && ra == 6'h3a |=>
		o_rd_data == 16'h0001)
		else $error("lot word wrong");
	a_unmapped_zero: assert property (i_rd_en && i_rd_addr < 7'h60 |=>
		o_rd_data == 16'h0000)
		else $error("unmapped read not zero");
	cover property (o_backup_done);
	cover property (i_rd_en && ra == 6'h3f);
	cover property (go ##2 i_wr_en);
	cover property (o_backup_busy && i_wr_en);
endmodule // isfc_bank_asserts

bind isfc_bank isfc_bank_asserts u_chk (.i_core_clk, .i_sys_rst,
	.i_wr_en, .i_wr_addr, .i_wr_data, .i_rd_en, .i_rd_addr,
	.o_rd_data, .o_backup_busy, .o_backup_done);

// file: test/isfc_host_model.sv
// Host model issuing register writes, reads and backup commands
module isfc_host_model (
	input wire i_core_clk,
	input wire [15:0] i_rd_data,
	output logic o_wr_en = 1'b0,
	output logic [6:0] o_wr_addr = 7'h00,
	output logic [7:0] o_wr_data = 8'h00,
	output logic o_rd_en = 1'b0,
	output logic [6:0] o_rd_addr = 7'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle lines show the inverse so stale values never look valid
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge i_core_clk) #1;
		o_wr_en = 1'b1;
		o_wr_addr = a;
		o_wr_data = d;
		@(posedge i_core_clk) #1;
		o_wr_en = 1'b0;
		o_wr_addr = ~a;
		o_wr_data = ~d;
	endtask
	task automatic rd(input logic [6:0] a, output logic [15:0] q);
		@(posedge i_core_clk) #1;
		o_rd_en = 1'b1;
		o_rd_addr = a;
		@(posedge i_core_clk) #1;
		o_rd_en = 1'b0;
		o_rd_addr = ~a;
		q = i_rd_data;
	endtask
	task automatic backup();
		wr(7'h68, 8'h08);
		wr(7'h69, 8'h00);
	endtask
endmodule // isfc_host_model

// file: test/isfc_bank_bench.sv
// Self-checking bench for the ident, scratch and tally bank
module isfc_bank_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, we, re, busy, done;
	logic [6:0] wa, ra;
	logic [7:0] wd;
	logic [15:0] rdata, q;
	int fails = 0, checked = 0;
	int dones = 0;
	isfc_bank dut (.i_core_clk(clk), .i_sys_rst(rst), .i_wr_en(we),
		.i_wr_addr(wa), .i_wr_data(wd), .i_rd_en(re), .i_rd_addr(ra),
		.o_rd_data(rdata), .o_backup_busy(busy), .o_backup_done(done));
	isfc_host_model host (.i_core_clk(clk), .i_rd_data(rdata),
		.o_wr_en(we), .o_wr_addr(wa), .o_wr_data(wd), .o_rd_en(re),
		.o_rd_addr(ra));
	initial begin
		forever #20 clk = ~clk;
	end
	// Done is a one-cycle pulse; count it so no poll can miss it
	always @(posedge clk) begin
		if (done === 1'b1)
			dones++;
	end
	task automatic wait_backup(input int d0);
		for (int n = 0; n < 20 && dones == d0; n++) begin
			@(posedge clk) #1;
		end
		if (dones == d0)
			fails++;
	endtask
	task automatic chk(input string n, input logic [15:0] got, exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s exp %h got %h", n, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic t_ident();
		host.rd(7'h6e, q);
		chk("mday", q, 16'h0101);
		host.rd(7'h71, q);
		chk("year", q, 16'h2000);
		host.wr(7'h72, 8'hff);
		host.wr(7'h73, 8'hff);
		host.rd(7'h73, q);
		chk("prod", q, 16'h1234);
		host.rd(7'h74, q);
		chk("lot", q, 16'h0001);
	endtask
	task automatic t_scratch();
		for (int i = 0; i < 3; i++) begin
			host.wr(7'h76 + 7'(2 * i), 8'h10 + 8'(i));
			host.wr(7'h77 + 7'(2 * i), 8'hc0 + 8'(i));
		end
		for (int i = 0; i < 3; i++) begin
			host.rd(7'h76 + 7'(2 * i), q);
			chk("note", q, {8'hc0 + 8'(i), 8'h10 + 8'(i)});
		end
		host.rd(7'h00, q);
		chk("unmapped", q, 16'h0000);
	endtask
	task automatic t_backup();
		int d0;
		host.rd(7'h7c, q);
		chk("tally lo", q, 16'h0000);
		d0 = dones;
		host.wr(7'h68, 8'h08);
		chk("busy", {15'h0000, busy}, 16'h0001);
		// Scratch write during the copy must be refused
		host.wr(7'h7b, 8'hee);
		host.wr(7'h69, 8'h00);
		wait_backup(d0);
		host.wr(7'h7c, 8'h55);
		host.rd(7'h7c, q);
		chk("tally lo", q, 16'h0001);
		host.rd(7'h7e, q);
		chk("tally hi", q, 16'h0000);
		host.rd(7'h7a, q);
		chk("note c", q, 16'hc212);
		d0 = dones;
		host.backup();
		wait_backup(d0);
		host.rd(7'h7d, q);
		chk("tally lo two", q, 16'h0002);
	endtask
	task automatic t_reset();
		@(posedge clk) #1 rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		chk("rd after rst", rdata, 16'h0000);
		host.rd(7'h76, q);
		chk("note a rst", q, 16'h0000);
		host.rd(7'h7c, q);
		chk("tally rst", q, 16'h0000);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		t_ident();
		t_scratch();
		t_backup();
		t_reset();
		tally_and_finish();
	end
endmodule // isfc_bank_bench
